// >>> hw/port_objects_pkg.sv
// Constants and types of the port settings object dictionary.
// Assumes a single 50 MHz system clock; objects are reached by index and subindex.
package port_objects_pkg;

   localparam int NUM_PORTS = 4;
   localparam int PD_BYTES = 32;
   localparam int PD_BITS = PD_BYTES * 8;

   // Object indices and subindices.
   localparam logic [15:0] IDX_RESTORE = 16'h1011;
   localparam logic [7:0] SUB_RESTORE_COUNT = 8'h00;
   localparam logic [7:0] SUB_RESTORE_TRIGGER = 8'h01;
   localparam logic [7:0] RESTORE_COUNT_VAL = 8'h01;
   localparam logic [31:0] RESTORE_SIGNATURE = 32'h6461_6F6C;

   localparam logic [7:0] IDX_SET_HI = 8'h80;
   localparam logic [3:0] IDX_SET_LO = 4'h0;
   localparam logic [7:0] SUB_MAX = 8'h00;
   localparam logic [7:0] SUB_DEVICE_ID = 8'h04;
   localparam logic [7:0] SUB_VENDOR_ID = 8'h05;
   localparam logic [7:0] SUB_REVISION = 8'h20;
   localparam logic [7:0] SUB_FEATURES = 8'h21;
   localparam logic [7:0] SUB_MIN_CYCLE = 8'h22;
   localparam logic [7:0] MAX_SUBINDEX_VAL = 8'h28;

   localparam logic [7:0] IDX_MAP_HI = 8'h60;
   localparam logic [3:0] MAP_PORT_MAX = 4'h3;

   // Reset values of the per-port settings.
   localparam logic [31:0] DEVICE_ID_RST = 32'h0000_0000;
   localparam logic [31:0] VENDOR_ID_RST = 32'h0000_0000;
   localparam logic [7:0] REVISION_RST = 8'h00;
   localparam logic [7:0] FEATURES_RST = 8'h00;
   localparam logic [7:0] MIN_CYCLE_RST = 8'h00;

   // Field positions.
   localparam int REV_MINOR_LSB = 0;
   localparam int REV_MAJOR_LSB = 4;
   localparam int FEAT_ISDU_BIT = 0;
   localparam int FEAT_FRAME_TYPE_ONE_FLAG_BIT = 1;
   localparam int FEAT_PHY_VARIANT_ONE_FLAG_BIT = 7;
   localparam int MCT_BASE_LSB = 6;
   localparam int MCT_MULT_LSB = 0;

   // Minimum cycle time decode in units of 0.1 ms.
   localparam logic [12:0] MCT_OFS_B0 = 13'd0;
   localparam logic [12:0] MCT_OFS_B1 = 13'd64;
   localparam logic [12:0] MCT_OFS_B2 = 13'd320;
   localparam logic [12:0] MCT_OFS_B3 = 13'd1344;
   localparam int MCT_SHIFT_B0 = 0;
   localparam int MCT_SHIFT_B1 = 2;
   localparam int MCT_SHIFT_B2 = 4;
   localparam int MCT_SHIFT_B3 = 6;

   // Data types of a mapping entry.
   typedef enum logic [3:0] {
      DT_BIT = 4'h0,
      DT_U32 = 4'h1,
      DT_S32 = 4'h2,
      DT_U16 = 4'h3,
      DT_S16 = 4'h4
   } data_type_t;

   // Default mapping: unsigned 16-bit from byte 0 of the first port.
   localparam logic [1:0] MAP_PORT_RST = 2'd0;
   localparam data_type_t MAP_TYPE_RST = DT_U16;
   localparam logic [7:0] MAP_OFFSET_RST = 8'h00;

   typedef enum logic [1:0] {
      RSP_OK = 2'b00,
      RSP_NO_OBJECT = 2'b01,
      RSP_READ_ONLY = 2'b11,
      RSP_BAD_VALUE = 2'b10
   } rsp_code_t;

endpackage

// >>> hw/cycle_time_decode.sv
// Converts a minimum cycle time byte into a time in units of 0.1 ms.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module cycle_time_decode
(
   input wire logic [7:0] code,
   output logic [12:0] tenths_ms
);
   import port_objects_pkg::*;

   logic [1:0] base;
   logic [12:0] mult;

   always_comb
   begin
      base = code[MCT_BASE_LSB +: 2];
      mult = {7'h00, code[MCT_MULT_LSB +: 6]};
      unique case (base)
         2'b00: tenths_ms = MCT_OFS_B0 + (mult << MCT_SHIFT_B0);
         2'b01: tenths_ms = MCT_OFS_B1 + (mult << MCT_SHIFT_B1);
         2'b10: tenths_ms = MCT_OFS_B2 + (mult << MCT_SHIFT_B2);
         2'b11: tenths_ms = MCT_OFS_B3 + (mult << MCT_SHIFT_B3);
      endcase
   end
endmodule // cycle_time_decode

// >>> hw/io_port_settings_object_map.sv
// Object dictionary of a four-port sensor-link master: settings, restore and safety mapping.
// Assumes a mailbox agent issuing one-cycle object requests and link ports supplying process data.
// Responses are one-cycle pulses; settings hold until rewritten, restored or reset.
`timescale 1ns/10ps
module io_port_settings_object_map
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic obj_req,
   input wire logic obj_write,
   input wire logic [15:0] obj_index,
   input wire logic [7:0] obj_subindex,
   input wire logic [31:0] obj_wdata,
   output logic obj_ack,
   output logic [1:0] obj_status,
   output logic [31:0] obj_rdata,
   input wire logic [port_objects_pkg::NUM_PORTS-1:0][port_objects_pkg::PD_BITS-1:0] port_pd_in,
   input wire logic [port_objects_pkg::NUM_PORTS-1:0][31:0] link_device_id,
   input wire logic [port_objects_pkg::NUM_PORTS-1:0][31:0] link_maker_code,
   output logic [31:0] safety_image,
   output logic [3:0] safety_image_type,
   output logic [port_objects_pkg::NUM_PORTS-1:0] device_id_match,
   output logic [port_objects_pkg::NUM_PORTS-1:0] maker_code_match,
   output logic [port_objects_pkg::NUM_PORTS-1:0][3:0] revision_minor,
   output logic [port_objects_pkg::NUM_PORTS-1:0][3:0] revision_major,
   output logic [port_objects_pkg::NUM_PORTS-1:0] isdu_support_flag,
   output logic [port_objects_pkg::NUM_PORTS-1:0] frame_type_one_flag,
   output logic [port_objects_pkg::NUM_PORTS-1:0] phy_variant_one_flag,
   output logic [port_objects_pkg::NUM_PORTS-1:0][12:0] min_cycle_tenths_ms
);
   import port_objects_pkg::*;

   typedef struct packed {
      logic [NUM_PORTS-1:0][31:0] exp_device_id;
      logic [NUM_PORTS-1:0][31:0] exp_maker_code;
      logic [NUM_PORTS-1:0][7:0] revision;
      logic [NUM_PORTS-1:0][7:0] features;
      logic [NUM_PORTS-1:0][7:0] min_cycle;
      logic [1:0] map_port;
      data_type_t map_type;
      logic [7:0] map_offset;
      logic ack;
      rsp_code_t status;
      logic [31:0] rdata;
      logic [31:0] image;
      logic [NUM_PORTS-1:0] dev_match;
      logic [NUM_PORTS-1:0] maker_match;
      logic [NUM_PORTS-1:0][12:0] mct;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [NUM_PORTS-1:0][12:0] mct_decoded;

   // Number of bytes a data type occupies.
   function automatic logic [7:0] type_bytes(input data_type_t t);
      unique case (t)
         DT_BIT: type_bytes = 8'd1;
         DT_U32, DT_S32: type_bytes = 8'd4;
         DT_U16, DT_S16: type_bytes = 8'd2;
         default: type_bytes = 8'd0;
      endcase
   endfunction

   // Checks a mapping request for a legal port, type and offset.
   function automatic logic map_legal(input logic [3:0] port, input logic [3:0] dtype, input logic [7:0] sub);
      logic [8:0] last;
      last = {1'b0, sub} - 9'd1 + {1'b0, type_bytes(data_type_t'(dtype))};
      map_legal = (port <= MAP_PORT_MAX) && (dtype <= 4'(DT_S16)) && (sub != 8'h00)
         && (last <= 9'(PD_BYTES));
   endfunction

   // Extracts and extends the mapped value from a port's process data.
   function automatic logic [31:0] extract(input logic [PD_BITS-1:0] pd, input data_type_t t, input logic [7:0] ofs);
      logic [PD_BITS-1:0] sh;
      logic [31:0] raw;
      sh = pd >> ({3'b000, ofs} << 3);
      raw = sh[31:0];
      unique case (t)
         DT_BIT: extract = {31'h0, raw[0]};
         DT_U32, DT_S32: extract = raw;
         DT_U16: extract = {16'h0000, raw[15:0]};
         DT_S16: extract = {{16{raw[15]}}, raw[15:0]};
         default: extract = 32'h0000_0000;
      endcase
   endfunction

   // Widens a byte object to the width of the read data.
   function automatic logic [31:0] byte_word(input logic [7:0] v);
      byte_word = {24'h00_0000, v};
   endfunction

   // Recognises the index of one of the port settings groups.
   function automatic logic settings_index(input logic [15:0] idx);
      settings_index = (idx[15:8] == IDX_SET_HI) && (idx[7:6] == 2'b00) && (idx[3:0] == IDX_SET_LO);
   endfunction

   // Recognises the index of a safety mapping entry.
   function automatic logic map_index(input logic [15:0] idx);
      map_index = (idx[15:8] == IDX_MAP_HI);
   endfunction

   // An expected identifier of zero switches its check off.
   function automatic logic id_matches(input logic [31:0] expected, input logic [31:0] reported);
      id_matches = (expected == 32'h0000_0000) || (expected == reported);
   endfunction

   // Returns the state with every backed-up setting at its factory value.
   function automatic state_t restore_settings(input state_t s);
      state_t r;
      r = s;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         r.exp_device_id[p] = DEVICE_ID_RST;
         r.exp_maker_code[p] = VENDOR_ID_RST;
         r.revision[p] = REVISION_RST;
         r.features[p] = FEATURES_RST;
         r.min_cycle[p] = MIN_CYCLE_RST;
      end
      restore_settings = r;
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++)
      begin : g_mct
         cycle_time_decode u_dec
         (
            .code(s_q.min_cycle[g]),
            .tenths_ms(mct_decoded[g])
         );
      end
   endgenerate

   always_comb
   begin
      logic [1:0] ch;
      logic set_hit;
      s_d = s_q;
      ch = obj_index[5:4];
      set_hit = settings_index(obj_index);
      s_d.ack = 1'b0;
      s_d.status = RSP_OK;
      s_d.rdata = 32'h0000_0000;

      if (obj_req)
      begin
         s_d.ack = 1'b1;
         if (obj_index == IDX_RESTORE)
         begin
            if (obj_subindex == SUB_RESTORE_COUNT)
            begin
               if (obj_write)
                  s_d.status = RSP_READ_ONLY;
               else
                  s_d.rdata = byte_word(RESTORE_COUNT_VAL);
            end
            else if (obj_subindex == SUB_RESTORE_TRIGGER)
            begin
               if (obj_write && (obj_wdata == RESTORE_SIGNATURE))
                  s_d = restore_settings(s_d);
            end
            else
               s_d.status = RSP_NO_OBJECT;
         end
         else if (set_hit)
         begin
            unique case (obj_subindex)
               SUB_MAX:
               begin
                  if (obj_write)
                     s_d.status = RSP_READ_ONLY;
                  else
                     s_d.rdata = byte_word(MAX_SUBINDEX_VAL);
               end
               SUB_DEVICE_ID:
               begin
                  if (obj_write)
                     s_d.exp_device_id[ch] = obj_wdata;
                  s_d.rdata = s_q.exp_device_id[ch];
               end
               SUB_VENDOR_ID:
               begin
                  if (obj_write)
                     s_d.exp_maker_code[ch] = obj_wdata;
                  s_d.rdata = s_q.exp_maker_code[ch];
               end
               SUB_REVISION:
               begin
                  if (obj_write)
                     s_d.revision[ch] = obj_wdata[7:0];
                  s_d.rdata = byte_word(s_q.revision[ch]);
               end
               SUB_FEATURES:
               begin
                  if (obj_write)
                     s_d.features[ch] = obj_wdata[7:0];
                  s_d.rdata = byte_word(s_q.features[ch]);
               end
               SUB_MIN_CYCLE:
               begin
                  if (obj_write)
                     s_d.min_cycle[ch] = obj_wdata[7:0];
                  s_d.rdata = byte_word(s_q.min_cycle[ch]);
               end
               default:
                  s_d.status = RSP_NO_OBJECT;
            endcase
         end
         else if (map_index(obj_index))
         begin
            if (obj_write)
            begin
               if (map_legal(obj_index[7:4], obj_index[3:0], obj_subindex))
               begin
                  s_d.map_port = obj_index[5:4];
                  s_d.map_type = data_type_t'(obj_index[3:0]);
                  s_d.map_offset = obj_subindex - 8'h01;
               end
               else
                  s_d.status = RSP_BAD_VALUE;
            end
            else
               s_d.rdata = s_q.image;
         end
         else
            s_d.status = RSP_NO_OBJECT;
      end

      s_d.image = extract(port_pd_in[s_q.map_port], s_q.map_type, s_q.map_offset);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         s_d.dev_match[p] = id_matches(s_q.exp_device_id[p], link_device_id[p]);
         s_d.maker_match[p] = id_matches(s_q.exp_maker_code[p], link_maker_code[p]);
         s_d.mct[p] = mct_decoded[p];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            s_q.exp_device_id[p] <= DEVICE_ID_RST;
            s_q.exp_maker_code[p] <= VENDOR_ID_RST;
            s_q.revision[p] <= REVISION_RST;
            s_q.features[p] <= FEATURES_RST;
            s_q.min_cycle[p] <= MIN_CYCLE_RST;
            s_q.mct[p] <= 13'h0000;
         end
         s_q.map_port <= MAP_PORT_RST;
         s_q.map_type <= MAP_TYPE_RST;
         s_q.map_offset <= MAP_OFFSET_RST;
         s_q.ack <= 1'b0;
         s_q.status <= RSP_OK;
         s_q.rdata <= 32'h0000_0000;
         s_q.image <= 32'h0000_0000;
         s_q.dev_match <= '0;
         s_q.maker_match <= '0;
      end
      else
         s_q <= s_d;
   end

   assign obj_ack = s_q.ack;
   assign obj_status = s_q.status;
   assign obj_rdata = s_q.rdata;
   assign safety_image = s_q.image;
   assign safety_image_type = 4'(s_q.map_type);
   assign device_id_match = s_q.dev_match;
   assign maker_code_match = s_q.maker_match;
   assign min_cycle_tenths_ms = s_q.mct;

   generate
      for (g = 0; g < NUM_PORTS; g++)
      begin : g_fields
         assign revision_minor[g] = s_q.revision[g][REV_MINOR_LSB +: 4];
         assign revision_major[g] = s_q.revision[g][REV_MAJOR_LSB +: 4];
         assign isdu_support_flag[g] = s_q.features[g][FEAT_ISDU_BIT];
         assign frame_type_one_flag[g] = s_q.features[g][FEAT_FRAME_TYPE_ONE_FLAG_BIT];
         assign phy_variant_one_flag[g] = s_q.features[g][FEAT_PHY_VARIANT_ONE_FLAG_BIT];
      end
   endgenerate
endmodule // io_port_settings_object_map

// >>> verif/io_port_settings_object_map_assertions.sv
// Concurrent checks on the object dictionary ports.
// Assumes one-cycle requests answered one cycle after the taking edge.
`timescale 1ns/10ps
module io_port_settings_object_map_assertions
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic obj_req,
   input wire logic obj_write,
   input wire logic [15:0] obj_index,
   input wire logic [7:0] obj_subindex,
   input wire logic [31:0] obj_wdata,
   input wire logic obj_ack,
   input wire logic [1:0] obj_status,
   input wire logic [3:0] safety_image_type,
   input wire logic [port_objects_pkg::NUM_PORTS-1:0][3:0] revision_minor,
   input wire logic [port_objects_pkg::NUM_PORTS-1:0][3:0] revision_major,
   input wire logic [port_objects_pkg::NUM_PORTS-1:0] frame_type_one_flag
);
   import port_objects_pkg::*;
   wire logic wr = obj_req && obj_write;
   wire logic set_wr = wr && obj_index[15:8] == 8'h80 && obj_index[3:0] == 4'h0 && obj_index[7:6] == 2'b00;
   wire logic map_wr = wr && obj_index[15:8] == 8'h60;
   wire logic rst_wr = wr && obj_index == 16'h1011 && obj_subindex == 8'h01;
   wire logic [1:0] ch = obj_index[5:4];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   property p_ack;
      obj_req |=> obj_ack ##1 (obj_ack == $past(obj_req));
   endproperty
   a_ack: assert property (p_ack) else $error("ack does not follow request");
   property p_rev;
      set_wr && obj_subindex == 8'h20 |=> {revision_major[$past(ch)], revision_minor[$past(ch)]} == $past(obj_wdata[7:0]);
   endproperty
   a_rev: assert property (p_rev) else $error("revision fields wrong");
   property p_feat;
      set_wr && obj_subindex == 8'h21 |=> frame_type_one_flag[$past(ch)] == $past(obj_wdata[1]);
   endproperty
   a_feat: assert property (p_feat) else $error("frame type flag wrong");
   property p_ro;
      (set_wr || (wr && obj_index == 16'h1011)) && obj_subindex == 8'h00 |=> obj_status == 2'b11;
   endproperty
   a_ro: assert property (p_ro) else $error("read-only write accepted");
   property p_restore;
      rst_wr && obj_wdata == 32'h6461_6F6C |=> revision_minor == '0 && revision_major == '0;
   endproperty
   a_restore: assert property (p_restore) else $error("restore left settings");
   property p_keep;
      rst_wr && obj_wdata != 32'h6461_6F6C |=> $stable(revision_minor) && $stable(frame_type_one_flag);
   endproperty
   a_keep: assert property (p_keep) else $error("wrong value restored");
   property p_bad;
      map_wr && (obj_index[7:4] > 4'h3 || obj_index[3:0] > 4'h4) |=> obj_status == 2'b10 && $stable(safety_image_type);
   endproperty
   a_bad: assert property (p_bad) else $error("bad mapping accepted");
   property p_type;
      map_wr && obj_index[7:4] <= 4'h3 && obj_index[3:0] <= 4'h4 && obj_subindex == 8'h01
         |=> obj_status == 2'b00 && safety_image_type == $past(obj_index[3:0]);
   endproperty
   a_type: assert property (p_type) else $error("mapping type wrong");
   property p_sub0;
      map_wr && obj_subindex == 8'h00 |=> obj_status == 2'b10;
   endproperty
   a_sub0: assert property (p_sub0) else $error("subindex zero accepted");
endmodule // io_port_settings_object_map_assertions
bind io_port_settings_object_map io_port_settings_object_map_assertions chk_u (.clk_sys(clk_sys), .nrst(nrst),
   .obj_req(obj_req), .obj_write(obj_write), .obj_index(obj_index), .obj_subindex(obj_subindex),
   .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_status(obj_status), .safety_image_type(safety_image_type),
   .revision_minor(revision_minor), .revision_major(revision_major), .frame_type_one_flag(frame_type_one_flag));

// >>> verif/link_device_model.sv
// Sensor-link devices on the four ports.
// Assumes the bench pulses step to advance the process data.
`timescale 1ns/10ps
module link_device_model
(
   input wire logic clk_sys,
   input wire logic step,
   output logic [port_objects_pkg::NUM_PORTS-1:0][port_objects_pkg::PD_BITS-1:0] port_pd_in,
   output logic [port_objects_pkg::NUM_PORTS-1:0][31:0] link_device_id,
   output logic [port_objects_pkg::NUM_PORTS-1:0][31:0] link_maker_code
);
   import port_objects_pkg::*;
   logic [31:0] seq_q = 32'h0000_001D;
   always @(posedge clk_sys)
      if (step)
         seq_q <= {seq_q[30:0], seq_q[31] ^ seq_q[21] ^ seq_q[1] ^ seq_q[0]};
   always_comb
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         for (int k = 0; k < PD_BYTES; k++)
            port_pd_in[p][8*k +: 8] = seq_q[8*(k%4) +: 8] ^ 8'(7 * k + 3 * p);
         link_device_id[p] = {seq_q[15:0], 16'(p + 1)};
         link_maker_code[p] = {16'(p + 1), seq_q[31:16]};
      end
endmodule // link_device_model

// >>> verif/tb_top.sv
// Self-checking bench of the object dictionary.
// Assumes the link device model on the port side.
`timescale 1ns/10ps
module tb_top;
   import port_objects_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic obj_req = 1'b0;
   logic obj_write = 1'b0;
   logic [15:0] obj_index = 16'h0000;
   logic [7:0] obj_subindex = 8'h00;
   logic [31:0] obj_wdata = 32'h0000_0000;
   logic step = 1'b0;
   logic obj_ack;
   logic [1:0] obj_status, st;
   logic [31:0] obj_rdata, safety_image, rd;
   logic [31:0] rnd = 32'h0000_001D;
   logic [3:0] safety_image_type;
   logic [NUM_PORTS-1:0][PD_BITS-1:0] port_pd_in;
   logic [NUM_PORTS-1:0][31:0] link_device_id, link_maker_code;
   logic [NUM_PORTS-1:0] device_id_match, maker_code_match;
   logic [NUM_PORTS-1:0] isdu_support_flag, frame_type_one_flag, phy_variant_one_flag;
   logic [NUM_PORTS-1:0][3:0] revision_minor, revision_major;
   logic [NUM_PORTS-1:0][12:0] min_cycle_tenths_ms;
   logic [23:0] cfg [NUM_PORTS];
   int o, p;
   int mismatches = 0;
   int tests_run = 0;
   always #10 clk_sys = ~clk_sys;
   link_device_model link_u (.clk_sys(clk_sys), .step(step), .port_pd_in(port_pd_in),
      .link_device_id(link_device_id), .link_maker_code(link_maker_code));
   io_port_settings_object_map dut (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [15:0] sidx(input int n);
      return {8'h80, 2'b00, 2'(n), 4'h0};
   endfunction
   function automatic logic [12:0] mct(input logic [7:0] c);
      logic [12:0] b;
      b = (c[7:6] == 2'd0) ? 13'h0000 : (c[7:6] == 2'd1) ? 13'h0040 : (c[7:6] == 2'd2) ? 13'h0140 : 13'h0540;
      return b + (13'(c[5:0]) << (2 * c[7:6]));
   endfunction
   function automatic logic [31:0] img(input int n, input int t, input int k);
      logic [31:0] w;
      w = port_pd_in[n][8*k +: 32];
      case (t)
         0: return {31'h0, w[0]};
         3: return {16'h0000, w[15:0]};
         4: return {{16{w[15]}}, w[15:0]};
         default: return w;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
      @(posedge clk_sys);
      obj_req <= 1'b1;
      obj_write <= w;
      obj_index <= i;
      obj_subindex <= s;
      obj_wdata <= d;
      @(posedge clk_sys);
      obj_req <= 1'b0;
      #1;
      chk(32'(obj_ack), 32'h0000_0001);
      st = obj_status;
      rd = obj_rdata;
   endtask
   task automatic summarize;
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      summarize();
   end
   initial
   begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      tick(2);
      chk(32'(safety_image_type), 32'h0000_0003);
      chk(safety_image, img(0, 3, 0));
      chk(32'({device_id_match, maker_code_match}), 32'h0000_00FF);
      obj(1'b0, 16'h1011, 8'h00, '0);
      chk(rd, 32'h0000_0001);
      obj(1'b1, 16'h1011, 8'h00, '0);
      chk(32'(st), 32'h0000_0003);
      obj(1'b0, 16'h8040, 8'h04, '0);
      chk(32'(st), 32'h0000_0001);
      for (int n = 0; n < 4; n++)
      begin
         obj(1'b0, sidx(n), 8'h00, '0);
         chk(rd, 32'h0000_0028);
         obj(1'b1, sidx(n), 8'h00, '0);
         chk(32'(st), 32'h0000_0003);
         rnd = lfsr(rnd);
         cfg[n] = (n == 3) ? {8'hFF, rnd[15:0]} : (n == 0) ? {8'h40, rnd[15:0]} : rnd[23:0];
         for (int k = 0; k < 3; k++)
            obj(1'b1, sidx(n), 8'h20 + 8'(k), {24'h000000, cfg[n][8*k +: 8]});
      end
      $display("test registers done");
      tick(3);
      for (int n = 0; n < 4; n++)
      begin
         chk(32'({revision_major[n], revision_minor[n]}), 32'(cfg[n][7:0]));
         chk(32'({phy_variant_one_flag[n], frame_type_one_flag[n], isdu_support_flag[n]}),
            32'({cfg[n][15], cfg[n][9:8]}));
         chk(32'(min_cycle_tenths_ms[n]), 32'(mct(cfg[n][23:16])));
         obj(1'b0, sidx(n), 8'h22, '0);
         chk(rd, 32'(cfg[n][23:16]));
         obj(1'b1, sidx(n), 8'h04, link_device_id[n] ^ 32'(n == 1));
         obj(1'b1, sidx(n), 8'h05, link_maker_code[n] ^ 32'(n == 2));
      end
      tick(2);
      chk(32'(device_id_match), 32'h0000_000D);
      chk(32'(maker_code_match), 32'h0000_000B);
      obj(1'b1, 16'h1011, 8'h01, 32'h6461_6F6D);
      tick(3);
      chk(32'({revision_major[3], revision_minor[3], device_id_match}), 32'({cfg[3][7:0], 4'hD}));
      obj(1'b1, 16'h1011, 8'h01, 32'h6461_6F6C);
      tick(3);
      chk(32'({revision_major, revision_minor}), 32'h0000_0000);
      chk(32'({device_id_match, maker_code_match, phy_variant_one_flag, frame_type_one_flag, isdu_support_flag}),
         32'h000F_F000);
      chk(32'(|min_cycle_tenths_ms), 32'h0000_0000);
      $display("test settings done");
      for (int t = 0; t < 5; t++)
      begin
         rnd = lfsr(rnd);
         o = (t == 0) ? 0 : (t == 1) ? 28 : int'(rnd % 29);
         p = t % 4;
         step <= 1'b1;
         @(posedge clk_sys);
         step <= 1'b0;
         obj(1'b1, {8'h60, 4'(p), 4'(t)}, 8'(o + 1), '0);
         chk(32'(st), 32'h0000_0000);
         tick(2);
         chk(32'(safety_image_type), 32'(t));
         chk(safety_image, img(p, t, o));
      end
      obj(1'b1, 16'h6040, 8'h01, '0);
      chk(32'(st), 32'h0000_0002);
      obj(1'b1, 16'h6005, 8'h01, '0);
      chk(32'(st), 32'h0000_0002);
      obj(1'b1, 16'h6013, 8'h00, '0);
      chk(32'(st), 32'h0000_0002);
      tick(2);
      chk(safety_image, img(0, 4, o));
      $display("test mapping done");
      summarize();
   end
endmodule // tb_top
